/* i2c_lock_pkg.sv */
/*
 * Shared constants for the locked memory-access target port, plus the
 * bit-level link engine that the packet logic instantiates.
 * Assumes one system clock (mclk) and an asynchronous active-high reset.
 */
`default_nettype none

package i2c_lock_pkg;
	// register port offsets
	localparam logic [3:0] REG_LOCK_CFG = 4'h0;
	localparam logic [3:0] REG_LOCK_KEY = 4'h4;
	localparam logic [3:0] REG_TARGET = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hc;
	// values after reset
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic [14:0] KEY_RST = 15'h0000;
	localparam logic [6:0] TARGET_RST = 7'h2a;
	// protection levels
	localparam logic [1:0] LVL_OPEN = 2'h0;
	localparam logic [1:0] LVL_KEY = 2'h1;
	localparam logic [1:0] LVL_RDKEY = 2'h2;
	// length codes
	localparam logic [1:0] LEN_16 = 2'h0;
	localparam logic [1:0] LEN_64 = 2'h2;
	localparam logic [1:0] LEN_RSV = 2'h3;
	// control word field positions
	localparam int CW_DIR = 23;
	localparam int CW_CRC = 22;
	// protected shadow window and the unlock location
	localparam logic [11:0] PROT_LO = 12'h080;
	localparam logic [11:0] PROT_HI = 12'h0af;
	localparam logic [11:0] UNLOCK_ADDR = 12'h0f8;
	localparam logic [21:0] ADDR2_STEP = 22'h000002;
	// crc defaults, overridable at the top
	localparam logic [7:0] CRC_POLY_DEF = 8'h07;
	localparam logic [7:0] CRC_INIT_DEF = 8'h00;

	// data bytes implied by a length code
	function automatic logic [3:0] len_bytes(input logic [1:0] len);
		case (len)
			2'h0: len_bytes = 4'h2;
			2'h1: len_bytes = 4'h4;
			2'h2: len_bytes = 4'h8;
			default: len_bytes = 4'h0;
		endcase
	endfunction

	// one crc-8 step over a byte, msb first
	function automatic logic [7:0] crc8(input logic [7:0] c,
		input logic [7:0] b, input logic [7:0] poly);
		logic [7:0] r;
		r = c ^ b;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ poly) : (r << 1);
		end
		crc8 = r;
	endfunction

	function automatic logic is_prot(input logic [11:0] a);
		is_prot = (a >= PROT_LO) && (a <= PROT_HI);
	endfunction

	// read permission from level and unlock state
	function automatic logic rd_ok(input logic [1:0] m,
		input logic unl, input logic bad);
		rd_ok = !bad && ((m == LVL_OPEN) ||
			((m == LVL_KEY || m == LVL_RDKEY) && unl));
	endfunction

	function automatic logic wr_ok(input logic [1:0] m,
		input logic unl, input logic bad);
		wr_ok = !bad && ((m == LVL_OPEN) || (m == LVL_KEY && unl));
	endfunction
endpackage

/*
 * bit engine: synchronises the link pins, finds start and stop, shifts
 * bytes in and out and drives the acknowledge slot.
 * Assumes scl comes from outside the mclk domain and is far slower.
 */
module i2c_bit_link (
	input wire logic mclk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic ack_req,
	input wire logic tx_mode,
	input wire logic [7:0] tx_byte,
	output logic start_p,
	output logic stop_p,
	output logic byte_p,
	output logic [7:0] rx_byte,
	output logic ack_p,
	output logic ctrl_nack,
	output logic sda_oe
);
	typedef struct packed {
		logic scl_m, scl_s, scl_p; // scl sync chain and history
		logic sda_m, sda_s, sda_p; // sda sync chain and history
		logic act; // inside a frame
		logic [3:0] cnt; // bit slot, 8 is the ack slot
		logic [7:0] sh; // receive shifter
		logic [7:0] tx; // transmit shifter
		logic oe; // pulling sda low
		logic bp, ap, nk; // byte done, ack slot done, nack seen
	} link_t;
	link_t q, d;
	logic rise, fall;
	logic [3:0] nc;

	// edges only look at the second sync stage and its history
	assign rise = q.scl_s & ~q.scl_p;
	assign fall = ~q.scl_s & q.scl_p;
	assign start_p = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
	assign stop_p = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
	assign byte_p = q.bp;
	assign rx_byte = q.sh;
	assign ack_p = q.ap;
	assign ctrl_nack = q.nk;
	assign sda_oe = q.oe;

	// next state of the link
	always_comb begin
		d = q;
		nc = (q.cnt == 4'h8) ? 4'h0 : q.cnt + 4'h1;
		d.scl_m = scl_in;
		d.scl_s = q.scl_m;
		d.scl_p = q.scl_s;
		d.sda_m = sda_in;
		d.sda_s = q.sda_m;
		d.sda_p = q.sda_s;
		d.bp = 1'b0;
		d.ap = 1'b0;
		if (start_p || stop_p) begin
			// a frame edge resets the slot count and frees the line
			d.act = start_p;
			// the scl fall that follows a start wraps 4'hf to bit slot 0
			d.cnt = start_p ? 4'hf : 4'h0;
			d.oe = 1'b0;
		end else if (q.act && rise) begin
			if (q.cnt < 4'h8) begin
				d.sh = {q.sh[6:0], q.sda_s};
			end
			d.bp = (q.cnt == 4'h7);
			d.ap = (q.cnt == 4'h8);
			if (q.cnt == 4'h8) begin
				d.nk = q.sda_s;
			end
		end else if (q.act && fall) begin
			d.cnt = nc;
			if (nc == 4'h8) begin
				// ack slot: pull low only for a byte the packet layer took;
				// a read request is acked before its first sent byte
				d.oe = ack_req;
			end else if (!tx_mode) begin
				d.oe = 1'b0;
			end else if (nc == 4'h0) begin
				d.tx = tx_byte;
				d.oe = ~tx_byte[7];
			end else begin
				d.tx = {q.tx[6:0], 1'b0};
				d.oe = ~q.tx[6];
			end
		end
	end

	// state register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q <= '{scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1, sda_m: 1'b1,
				sda_s: 1'b1, sda_p: 1'b1, default: '0};
		end else begin
			q <= d;
		end
	end
endmodule // i2c_bit_link

`default_nettype wire

/* i2c_target_mem_access_lock.sv */
/*
 * Packet layer of the memory-access target port: control word, write
 * commit, read prefetch, crc and the passcode lock.
 * Assumes the memory answers a read strobe with data one cycle later.
 */
`default_nettype none

module i2c_target_mem_access_lock #(
	parameter logic [7:0] CRC_POLY = i2c_lock_pkg::CRC_POLY_DEF,
	parameter logic [7:0] CRC_INIT = i2c_lock_pkg::CRC_INIT_DEF
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic sleep_p, // sleep entry drops the unlock
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic [21:0] mem_addr,
	output logic [31:0] mem_wdata,
	output logic mem_wr,
	output logic mem_wide, // 1: 32-bit word, 0: low 16 bits
	output logic mem_rd,
	input wire logic [31:0] mem_rdata
);
	import i2c_lock_pkg::*;

	typedef enum logic [3:0] {ST_IDLE, ST_ADDR, ST_CTRL, ST_WDATA,
		ST_RDPEND, ST_TX, ST_COMMIT2, ST_SKIP} phase_t;

	typedef struct packed {
		phase_t st;
		logic [23:0] cw; // control word, first byte on top
		logic [1:0] cwn; // control bytes taken
		logic [3:0] nb; // data bytes moved
		logic [63:0] wbuf; // write data, byte 0 lowest
		logic [63:0] rbuf; // prefetched read data
		logic [7:0] crc; // running crc
		logic crc_ok; // received crc matched
		logic acc_ok; // access allowed for this packet
		logic rd_pend; // read control word awaits restart
		logic ack; // acknowledge the current byte
		logic txm; // we drive data bytes
		logic [7:0] txb; // next byte to send
		logic [2:0] fph; // prefetch phase
		logic [1:0] mode; // protection level
		logic [14:0] key; // stored passcode
		logic [6:0] tid; // own target identifier
		logic unlocked;
		logic bad_key;
		logic [21:0] maddr;
		logic [31:0] mwdata;
		logic mwr, mwide, mrd;
		logic [31:0] rdata;
	} blk_t;
	blk_t q, d;

	logic start_p, stop_p, byte_p, ack_p, ctrl_nack;
	logic [7:0] rx;
	logic [23:0] ncw; // control word after the byte now arriving
	logic [21:0] base; // internal address of this packet
	logic [3:0] exp; // data bytes the length asks for
	logic [3:0] tot; // data bytes plus crc byte
	logic wgood; // write may be committed at stop
	logic [7:0] ncrc;

	i2c_bit_link u_link (
		.mclk(mclk),
		.rst(rst),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.ack_req(q.ack),
		.tx_mode(q.txm),
		.tx_byte(q.txb),
		.start_p(start_p),
		.stop_p(stop_p),
		.byte_p(byte_p),
		.rx_byte(rx),
		.ack_p(ack_p),
		.ctrl_nack(ctrl_nack),
		.sda_oe(sda_oe)
	);

	// open drain: only ever pull low
	assign sda_out = 1'b0;
	assign reg_rdata = q.rdata;
	assign mem_addr = q.maddr;
	assign mem_wdata = q.mwdata;
	assign mem_wr = q.mwr;
	assign mem_wide = q.mwide;
	assign mem_rd = q.mrd;

	// upper two bits pad the 20 carried bits to the internal width
	assign base = {2'b00, q.cw[19:0]};
	assign ncw = {q.cw[15:0], rx};
	assign exp = len_bytes(q.cw[21:20]);
	assign tot = exp + {3'b000, q.cw[CW_CRC]};
	// byte count, crc and lock re-checked at the commit
	assign wgood = q.acc_ok && (q.nb == tot) &&
		(!q.cw[CW_CRC] || q.crc_ok) &&
		(!is_prot(q.cw[11:0]) || wr_ok(q.mode, q.unlocked, q.bad_key));
	assign ncrc = crc8(q.crc, q.txb, CRC_POLY);

	// whole next-state logic of the packet layer
	always_comb begin
		d = q;
		d.mwr = 1'b0;
		d.mrd = 1'b0;
		d.rdata = 32'h00000000;
		// register port, read data one cycle after the strobe
		if (reg_rd) begin
			case (reg_addr)
				REG_LOCK_CFG: d.rdata = {30'h0, q.mode};
				REG_LOCK_KEY: d.rdata = 32'h00000000;
				REG_TARGET: d.rdata = {25'h0, q.tid};
				REG_STATUS: d.rdata = {27'h0, q.st != ST_IDLE,
					wr_ok(q.mode, q.unlocked, q.bad_key),
					rd_ok(q.mode, q.unlocked, q.bad_key),
					q.bad_key, q.unlocked};
				default: d.rdata = 32'h00000000;
			endcase
		end
		if (reg_wr) begin
			// lock fields obey the level they configure
			if (reg_addr == REG_LOCK_CFG &&
				wr_ok(q.mode, q.unlocked, q.bad_key)) begin
				d.mode = reg_wdata[1:0];
			end
			// only possible at levels 00 and 01
			if (reg_addr == REG_LOCK_KEY &&
				wr_ok(q.mode, q.unlocked, q.bad_key)) begin
				d.key = reg_wdata[14:0];
			end
			if (reg_addr == REG_TARGET) begin
				d.tid = reg_wdata[6:0];
			end
		end
		// sleep entry forgets the passcode entry
		if (sleep_p) begin
			d.unlocked = 1'b0;
			d.bad_key = 1'b0;
		end
		// read prefetch: strobe, then data a cycle later
		case (q.fph)
			3'h1: begin
				d.mrd = 1'b1;
				d.maddr = base;
				d.fph = 3'h2;
			end
			3'h2: begin
				if (q.cw[21:20] == LEN_64) begin
					d.mrd = 1'b1;
					d.maddr = base + ADDR2_STEP;
				end
				d.fph = 3'h3;
			end
			3'h3: begin
				d.rbuf[31:0] = mem_rdata;
				d.fph = (q.cw[21:20] == LEN_64) ? 3'h4 : 3'h0;
			end
			3'h4: begin
				d.rbuf[63:32] = mem_rdata;
				d.fph = 3'h0;
			end
			default: d.fph = 3'h0;
		endcase
		// second half of a 64-bit write
		if (q.st == ST_COMMIT2) begin
			d.mwr = 1'b1;
			d.mwide = 1'b1;
			d.maddr = q.maddr + ADDR2_STEP;
			d.mwdata = q.wbuf[63:32];
			d.st = ST_IDLE;
		end
		if (start_p) begin
			// repeated or fresh start; a pending read survives
			d.st = ST_ADDR;
			d.ack = 1'b0;
			d.txm = 1'b0;
			d.rd_pend = q.rd_pend && (q.st == ST_RDPEND);
		end else if (stop_p) begin
			d.ack = 1'b0;
			d.txm = 1'b0;
			d.st = (q.st == ST_RDPEND) ? ST_RDPEND : ST_IDLE;
			if (q.st != ST_RDPEND) begin
				d.rd_pend = 1'b0;
			end
			if (q.st == ST_WDATA && wgood) begin
				if (q.cw[11:0] == UNLOCK_ADDR) begin
					// one good entry unlocks, a wrong one locks out
					d.unlocked = (q.wbuf[14:0] == q.key);
					d.bad_key = (q.wbuf[14:0] != q.key);
				end else begin
					// first word at the given address
					d.mwr = 1'b1;
					d.maddr = base;
					d.mwide = (q.cw[21:20] != LEN_16);
					d.mwdata = (q.cw[21:20] == LEN_16) ?
						{16'h0000, q.wbuf[15:0]} : q.wbuf[31:0];
					if (q.cw[21:20] == LEN_64) begin
						d.st = ST_COMMIT2;
					end
				end
			end
		end else if (byte_p) begin
			d.ack = 1'b0;
			case (q.st)
				ST_ADDR: begin
					if (rx[7:1] != q.tid) begin
						d.st = ST_SKIP;
					end else if (!rx[0]) begin
						// every packet opens with a write
						d.ack = 1'b1;
						d.st = ST_CTRL;
						d.cwn = 2'h0;
						d.rd_pend = 1'b0;
						d.crc = crc8(CRC_INIT, rx, CRC_POLY);
					end else if (q.rd_pend && q.acc_ok) begin
						d.ack = 1'b1;
						d.txm = 1'b1;
						d.st = ST_TX;
						d.nb = 4'h0;
						d.txb = q.rbuf[7:0];
						d.crc = crc8(q.crc, rx, CRC_POLY);
					end else begin
						// refused reads get no answer
						d.st = ST_SKIP;
					end
				end
				ST_CTRL: begin
					d.ack = 1'b1;
					d.cw = ncw;
					d.cwn = q.cwn + 2'h1;
					d.crc = crc8(q.crc, rx, CRC_POLY);
					if (q.cwn == 2'h2) begin
						// reserved length or section/page: no access
						d.acc_ok = (ncw[21:20] != LEN_RSV) &&
							(ncw[19:12] == 8'h00);
						if (ncw[CW_DIR]) begin
							d.st = ST_RDPEND;
							d.rd_pend = 1'b1;
							if (is_prot(ncw[11:0]) &&
								!rd_ok(q.mode, q.unlocked, q.bad_key)) begin
								d.acc_ok = 1'b0;
							end
							if (d.acc_ok) begin
								d.fph = 3'h1;
							end
						end else begin
							d.st = ST_WDATA;
							d.nb = 4'h0;
							d.crc_ok = 1'b0;
							if (is_prot(ncw[11:0]) &&
								!wr_ok(q.mode, q.unlocked, q.bad_key)) begin
								d.acc_ok = 1'b0;
							end
						end
					end
				end
				ST_WDATA: begin
					// locked-out writes are not acknowledged
					d.ack = q.acc_ok;
					if (q.nb < exp) begin
						d.wbuf[{q.nb[2:0], 3'b000} +: 8] = rx;
						d.crc = crc8(q.crc, rx, CRC_POLY);
					end else if (q.nb == exp && q.cw[CW_CRC]) begin
						d.crc_ok = (rx == q.crc);
					end
					if (q.nb != 4'hf) begin
						d.nb = q.nb + 4'h1;
					end
				end
				default: d.ack = 1'b0;
			endcase
		end else if (ack_p && q.st == ST_TX && !q.ack) begin
			// controller answered a byte we sent; our own ack of the read
			// request also ends a slot and is told apart by q.ack
			if (q.nb < exp) begin
				d.crc = ncrc;
			end
			d.nb = q.nb + 4'h1;
			if (ctrl_nack) begin
				d.txm = 1'b0;
				d.rd_pend = 1'b0;
				d.st = ST_SKIP;
			end else if (q.nb + 4'h1 < exp) begin
				d.txb = q.rbuf[{q.nb[2:0] + 3'h1, 3'b000} +: 8];
			end else if (q.nb + 4'h1 == exp && q.cw[CW_CRC]) begin
				d.txb = ncrc;
			end else begin
				d.txb = 8'hff;
			end
		end
	end

	// state register; reset gives the documented power-up state
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q <= '{st: ST_IDLE, mode: MODE_RST, key: KEY_RST,
				tid: TARGET_RST, default: '0};
		end else begin
			q <= d;
		end
	end

	property p_wr_lock;
		@(posedge mclk) disable iff (rst)
		mem_wr && is_prot(mem_addr[11:0]) |->
			$past(wr_ok(q.mode, q.unlocked, q.bad_key));
	endproperty
	a_wr_lock: assert property (p_wr_lock)
		else $error("protected write while locked");

	property p_rd_lock;
		@(posedge mclk) disable iff (rst)
		mem_rd && is_prot(mem_addr[11:0]) && q.fph == 3'h2 |->
			$past(rd_ok(q.mode, q.unlocked, q.bad_key), 2);
	endproperty
	a_rd_lock: assert property (p_rd_lock)
		else $error("protected read while locked");

	property p_key_hidden;
		@(posedge mclk) disable iff (rst)
		reg_rd && reg_addr == REG_LOCK_KEY |=> reg_rdata == 32'h0;
	endproperty
	a_key_hidden: assert property (p_key_hidden)
		else $error("passcode became readable");

	property p_bad_key;
		@(posedge mclk) disable iff (rst)
		stop_p && q.st == ST_WDATA && wgood &&
			q.cw[11:0] == UNLOCK_ADDR && q.wbuf[14:0] != q.key
			|=> !q.unlocked && q.bad_key;
	endproperty
	a_bad_key: assert property (p_bad_key)
		else $error("wrong passcode left access open");

	property p_sec_page;
		@(posedge mclk) disable iff (rst)
		mem_wr || mem_rd |-> mem_addr[21:12] == 10'h000;
	endproperty
	a_sec_page: assert property (p_sec_page)
		else $error("access outside section and page zero");

	property p_rsv_len;
		@(posedge mclk) disable iff (rst)
		mem_wr |-> q.cw[21:20] != LEN_RSV;
	endproperty
	a_rsv_len: assert property (p_rsv_len)
		else $error("access for reserved length");

	property p_count;
		@(posedge mclk) disable iff (rst)
		$rose(mem_wr) |-> $past(q.nb) == $past(tot);
	endproperty
	a_count: assert property (p_count)
		else $error("write committed with wrong byte count");

	property p_second_word;
		@(posedge mclk) disable iff (rst)
		$rose(mem_wr) && q.st == ST_COMMIT2 |=>
			mem_wr && mem_addr == $past(mem_addr) + ADDR2_STEP
			##1 !mem_wr;
	endproperty
	a_second_word: assert property (p_second_word)
		else $error("64-bit write second word wrong");

	property p_foreign_id;
		@(posedge mclk) disable iff (rst)
		byte_p && q.st == ST_ADDR && rx[7:1] != q.tid |=>
			!q.ack && q.st == ST_SKIP;
	endproperty
	a_foreign_id: assert property (p_foreign_id)
		else $error("foreign identifier acknowledged");
endmodule // i2c_target_mem_access_lock

`default_nettype wire

/* i2c_ctl_model.sv */
/*
 * Controller model for the far side of the target port: start, stop,
 * byte send and byte receive over scl and an open-drain data line.
 * Assumes the bench resolves the data wire and that every task is
 * entered just after a rising mclk edge.
 */
`default_nettype none

module i2c_ctl_model #(
	parameter int GAP = 20 // byte gap in mclk cycles, shortened
) (
	input wire logic mclk,
	input wire logic sda, // resolved wire level
	output logic scl,
	output logic sda_oe // high pulls the data line low
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle bus: both lines released high
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end

	// set both lines just after an edge, then hold them n cycles
	task automatic line(input logic c, input logic d, input int n);
		scl <= c;
		sda_oe <= !d;
		repeat (n) @(posedge mclk);
	endtask

	// start or repeated start; a low clock is raised with data high
	task automatic start();
		if (!scl) line(1'b0, 1'b1, 4);
		line(1'b1, 1'b1, 3);
		line(1'b1, 1'b0, 3);
		line(1'b0, 1'b0, 2);
	endtask

	// every frame is closed by a stop
	task automatic stop();
		line(1'b0, 1'b0, 2);
		line(1'b1, 1'b0, 3);
		line(1'b1, 1'b1, 4);
	endtask

	// one bit, 8 cycles: data settles mid-low, held through high
	task automatic wbit(input logic b);
		line(1'b0, b, 2);
		line(1'b1, b, 4);
		line(1'b0, b, 2);
	endtask

	// sample late in the high phase so the target has settled
	task automatic rbit(output logic r);
		line(1'b0, 1'b1, 2);
		line(1'b1, 1'b1, 3);
		r = sda;
		line(1'b1, 1'b1, 1);
		line(1'b0, 1'b1, 2);
	endtask

	// msb first, then the target's acknowledge slot
	task automatic send(input logic [7:0] b, output logic ack);
		logic n;
		for (int i = 7; i >= 0; i--) wbit(b[i]);
		rbit(n);
		ack = !n;
		line(1'b0, 1'b1, GAP); // gap between bytes
	endtask

	// the last byte, crc included, gets the final nack
	task automatic recv(input logic last, output logic [7:0] b);
		for (int i = 7; i >= 0; i--) rbit(b[i]);
		wbit(last);
		line(1'b0, 1'b1, GAP);
	endtask
endmodule // i2c_ctl_model

`default_nettype wire

/* i2c_target_mem_access_lock_tb.sv */
/*
 * Self-checking bench for the locked memory-access target port.
 * Assumes the controller model is compiled first; a memory model here
 * answers each read strobe one cycle later.
 */
`default_nettype none

module i2c_target_mem_access_lock_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import i2c_lock_pkg::*;

	localparam logic [6:0] ID = TARGET_RST; // own identifier
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic sleep_p = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] mem_rdata = 32'h0;
	logic [31:0] reg_rdata, mem_wdata;
	logic [21:0] mem_addr;
	logic sda_out, dut_oe, ctl_oe, scl, mem_wr, mem_wide, mem_rd;
	wire logic sda = !(dut_oe || ctl_oe); // open drain, pulled up
	logic [22:0] wa_q[$]; // commits: {wide, address}
	logic [31:0] wd_q[$];
	logic [7:0] crc; // running crc of the frame
	logic [63:0] rd; // bytes read back
	int acks;
	logic ok;
	int n_errors = 0;
	int cmp_count = 0;

	always #25 mclk = ~mclk;

	i2c_target_mem_access_lock i2c_target_mem_access_lock_inst (
		.mclk(mclk), .rst(rst), .sleep_p(sleep_p), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(dut_oe),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_wide(mem_wide),
		.mem_rd(mem_rd), .mem_rdata(mem_rdata));

	i2c_ctl_model ctl_inst (.mclk(mclk), .sda(sda), .scl(scl),
		.sda_oe(ctl_oe));

	// address-derived pattern, so a wrong address shows in the data
	function automatic logic [31:0] pat(input logic [21:0] a);
		return {a[15:0] ^ 16'hc3a5, a[15:0]};
	endfunction

	// memory: record commits, answer reads one cycle later
	always @(posedge mclk) begin
		if (mem_rd) mem_rdata <= pat(mem_addr);
		if (mem_wr) begin
			wa_q.push_back({mem_wide, mem_addr});
			wd_q.push_back(mem_wdata);
		end
	end

	function automatic logic [7:0] crc_b(input logic [7:0] c,
		input logic [7:0] b);
		logic [7:0] r;
		r = c ^ b;
		for (int i = 0; i < 8; i++)
			r = r[7] ? {r[6:0], 1'b0} ^ CRC_POLY_DEF : {r[6:0], 1'b0};
		return r;
	endfunction

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic reg_w(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic reg_r(input logic [3:0] a, input logic [31:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, exp);
	endtask

	task automatic tx(input logic [7:0] b);
		crc = crc_b(crc, b);
		ctl_inst.send(b, ok);
		acks += ok;
	endtask

	// identifier with write bit, control word high byte first
	task automatic head(input logic [6:0] id, input logic [23:0] cw);
		crc = CRC_INIT_DEF;
		acks = 0;
		wa_q.delete();
		wd_q.delete();
		ctl_inst.start();
		tx({id, 1'b0});
		for (int i = 2; i >= 0; i--) tx(cw[8*i +: 8]);
	endtask

	// write frame with n data bytes, least significant first
	task automatic wr(input logic [6:0] id, input logic [23:0] cw,
		input logic [63:0] d, input int n);
		head(id, cw);
		for (int i = 0; i < n; i++) tx(d[8*i +: 8]);
		if (cw[CW_CRC]) tx(crc);
		check(wa_q.size(), 0);
		ctl_inst.stop();
		repeat (8) @(posedge mclk);
	endtask

	// read frame; rs picks repeated start over stop then start
	task automatic rdf(input logic [23:0] cw, input int n, input logic rs);
		logic [7:0] b;
		rd = '0;
		head(ID, cw);
		if (!rs) ctl_inst.stop();
		ctl_inst.start();
		tx({ID, 1'b1});
		for (int i = 0; ok && i < n + cw[CW_CRC]; i++) begin
			ctl_inst.recv(i == n - 1 + cw[CW_CRC], b);
			if (i < n) rd[8*i +: 8] = b;
			else check(b, crc);
			crc = crc_b(crc, b);
		end
		ctl_inst.stop();
	endtask

	// n commits expected, entry k compared; 16-bit data in low half
	task automatic exp_w(input int n, input int k, input logic [22:0] a,
		input logic [31:0] d);
		check(wa_q.size(), n);
		if (wa_q.size() > k) begin
			check(wa_q[k], a);
			check(a[22] ? wd_q[k] : wd_q[k] & 32'hffff, d);
		end
	endtask

	task automatic reset_dut();
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask

	initial begin
		repeat (90000) @(posedge mclk);
		n_errors++;
		complete_run();
	end

	initial begin
		reset_dut();
		reg_r(REG_LOCK_CFG, 32'h0);
		reg_r(REG_TARGET, {25'h0, TARGET_RST});
		reg_r(4'h1, 32'h0);
		reg_r(REG_STATUS, 32'hc);
		check(sda_out, 1'b0); // open drain only ever pulls low
		$display("test registers done");
		wr(ID, 24'h100080, 64'h1234abcd, 4);
		check(acks, 8);
		exp_w(1, 0, 23'h400080, 32'h1234abcd);
		wr(ID, 24'h000084, 64'hbeef, 2);
		exp_w(1, 0, 23'h000084, 32'hbeef);
		wr(ID, 24'h600088, 64'h89abcdef01234567, 8);
		check(acks, 13);
		exp_w(2, 0, 23'h400088, 32'h01234567);
		exp_w(2, 1, 23'h40008a, 32'h89abcdef);
		wr(ID, 24'h000084, 64'hccbbaa, 3);
		check(wa_q.size(), 0);
		wr(ID, 24'h100080, 64'h11, 1);
		check(wa_q.size(), 0);
		wr(ID, 24'h300080, 64'h1234abcd, 4);
		check(wa_q.size(), 0);
		wr(ID, 24'h110080, 64'h1234abcd, 4);
		check(wa_q.size(), 0);
		wr(ID ^ 7'h01, 24'h100080, 64'h1234abcd, 4);
		check(acks + wa_q.size(), 0);
		$display("test writes done");
		rdf(24'hd00090, 4, 1'b1);
		check(rd, {32'h0, pat(22'h90)});
		rdf(24'ha00098, 8, 1'b0);
		check(rd, {pat(22'h9a), pat(22'h98)});
		rdf(24'h800094, 2, 1'b1);
		check(rd, {32'h0, pat(22'h94) & 32'hffff});
		$display("test reads done");
		reg_w(REG_LOCK_KEY, 32'h1234);
		reg_r(REG_LOCK_KEY, 32'h0);
		reg_w(REG_LOCK_CFG, {30'h0, LVL_KEY});
		reg_r(REG_STATUS, 32'h0);
		wr(ID, 24'h100080, 64'h5555, 4);
		check(wa_q.size(), 0);
		wr(ID, 24'h1000f8, 64'h1234, 4);
		check(wa_q.size(), 0);
		reg_r(REG_STATUS, 32'hd);
		wr(ID, 24'h100080, 64'h5555, 4);
		exp_w(1, 0, 23'h400080, 32'h5555);
		reg_w(REG_LOCK_CFG, {30'h0, LVL_RDKEY});
		reg_r(REG_STATUS, 32'h5);
		reg_w(REG_LOCK_CFG, 32'h0);
		reg_r(REG_LOCK_CFG, {30'h0, LVL_RDKEY});
		wr(ID, 24'h100080, 64'h6666, 4);
		check(wa_q.size(), 0);
		rdf(24'hd00090, 4, 1'b1);
		check(ok, 1);
		wr(ID, 24'h1000f8, 64'h0001, 4);
		reg_r(REG_STATUS, 32'h2);
		rdf(24'hd00090, 4, 1'b1);
		check(ok, 0);
		wr(ID, 24'h1000f8, 64'h1234, 4);
		reg_r(REG_STATUS, 32'h5);
		@(posedge mclk);
		sleep_p <= 1'b1;
		@(posedge mclk);
		sleep_p <= 1'b0;
		reg_r(REG_STATUS, 32'h0);
		reset_dut();
		reg_r(REG_STATUS, 32'hc);
		reg_w(REG_LOCK_CFG, 32'h3);
		reg_r(REG_LOCK_CFG, 32'h3);
		reg_r(REG_STATUS, 32'h0);
		rdf(24'hd00090, 4, 1'b1);
		check(ok, 0);
		$display("test lock done");
		complete_run();
	end
endmodule // i2c_target_mem_access_lock_tb

`default_nettype wire
